/* eeg_pkg.sv */
// package: constants and check-code functions for the group error-correction block
package eeg_pkg;

  // =====================================================================
  // geometry
  localparam int EEG_ADDR_W = 16;
  localparam int EEG_GRP_BYTES = 4;
  localparam int EEG_PAGE_BYTES = 128;
  localparam int EEG_PTR_W = 7;
  localparam int EEG_GRP_IDX_W = 5;
  localparam int EEG_GRP_ADDR_W = EEG_ADDR_W - 2;
  localparam int EEG_PAGE_W = EEG_ADDR_W - EEG_PTR_W;
  localparam int EEG_WORD_W = 8 * EEG_GRP_BYTES;
  localparam int EEG_CHK_W = 6;
  localparam logic [EEG_GRP_IDX_W-1:0] EEG_LAST_GRP = 5'h1F;

  // =====================================================================
  // timing
  localparam int EEG_CLK_NS = 40;
  localparam int EEG_TWR_NS = 5000000;
  // longest time, so rounded down
  localparam int EEG_TWR_CYC = EEG_TWR_NS / EEG_CLK_NS;
  localparam int EEG_TWR_CNT_W = 17;

  // =====================================================================
  // check code: each data bit owns a non-power-of-two codeword position
  function automatic logic [EEG_CHK_W-1:0] eeg_pos(input int idx);
    int n;
    logic [EEG_CHK_W-1:0] r;
    n = 0;
    r = '0;
    for (int k = 3; k < 64; k++) begin
      if ((k & (k - 1)) != 0) begin
        if (n == idx) r = 6'(k);
        n++;
      end
    end
    return r;
  endfunction

  function automatic logic [EEG_CHK_W-1:0] eeg_check(input logic [EEG_WORD_W-1:0] d);
    logic [EEG_CHK_W-1:0] c;
    c = '0;
    for (int i = 0; i < EEG_WORD_W; i++) begin
      if (d[i]) c = c ^ eeg_pos(i);
    end
    return c;
  endfunction

  // a syndrome pointing at a check bit or at no valid position leaves data as stored
  function automatic logic [EEG_WORD_W-1:0] eeg_fix(input logic [EEG_WORD_W-1:0] d,
                                                    input logic [EEG_CHK_W-1:0] c);
    logic [EEG_CHK_W-1:0] s;
    logic [EEG_WORD_W-1:0] f;
    s = eeg_check(d) ^ c;
    f = d;
    for (int i = 0; i < EEG_WORD_W; i++) begin
      if (eeg_pos(i) == s) f[i] = ~d[i];
    end
    return f;
  endfunction

endpackage

/* eeg_group_ecc.sv */
// group error correction between the serial slave engine and the array
`timescale 1ns/1ps

module eeg_group_ecc
  import eeg_pkg::*;
#(
  parameter int TWR_CYCLES = EEG_TWR_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_begin,
  input wire logic wr_id_page,
  input wire logic [EEG_ADDR_W-1:0] wr_addr,
  input wire logic wr_data_valid,
  input wire logic [7:0] wr_data,
  input wire logic wr_stop,
  input wire logic rd_req,
  input wire logic [EEG_ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output logic arr_id_sel,
  output logic [EEG_GRP_ADDR_W-1:0] arr_grp,
  output logic arr_rd_en,
  input wire logic [EEG_WORD_W-1:0] arr_rd_data,
  input wire logic [EEG_CHK_W-1:0] arr_rd_chk,
  output logic arr_wr_en,
  output logic [EEG_WORD_W-1:0] arr_wr_data,
  output logic [EEG_CHK_W-1:0] arr_wr_chk
);

  localparam logic [EEG_TWR_CNT_W-1:0] TWR_LAST = EEG_TWR_CNT_W'(TWR_CYCLES - 1);

  typedef enum logic [3:0] {
    S_IDLE, S_LOAD, S_PRD, S_PWAIT, S_PMRG, S_PNEXT, S_TWR, S_RWAIT, S_RCAP
  } eeg_state_e;

  eeg_state_e state_reg;
  logic [7:0] buf_mem [EEG_PAGE_BYTES];
  logic [EEG_PAGE_BYTES-1:0] mask_reg;
  logic [EEG_PTR_W-1:0] ptr_reg;
  logic [EEG_PAGE_W-1:0] page_reg;
  logic [EEG_GRP_IDX_W-1:0] grp_reg;
  logic [1:0] lane_reg;
  logic [EEG_TWR_CNT_W-1:0] twr_cnt_reg;
  logic [EEG_WORD_W-1:0] old_word;
  logic [EEG_WORD_W-1:0] merge_word;
  logic grp_dirty;
  logic rd_take;

  assign old_word = eeg_fix(arr_rd_data, arr_rd_chk);
  assign grp_dirty = |mask_reg[{grp_reg, 2'h0} +: EEG_GRP_BYTES];
  // a read is taken exactly where the sequencer moves into the read states
  assign rd_take = rd_req && ((state_reg == S_IDLE && !wr_begin)
                              || (state_reg == S_LOAD && !wr_stop));

  // =====================================================================
  // merge: bytes not sent by the master keep their corrected old value
  for (genvar j = 0; j < EEG_GRP_BYTES; j++) begin : g_merge
    assign merge_word[8*j +: 8] = mask_reg[{grp_reg, 2'(j)}] ? buf_mem[{grp_reg, 2'(j)}]
                                                            : old_word[8*j +: 8];
  end

  // =====================================================================
  // sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= S_IDLE;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (wr_begin) state_reg <= S_LOAD;
          else if (rd_req) state_reg <= S_RWAIT;
        end
        S_LOAD: begin
          // a stop with no data was only an address set-up, so no write cycle
          if (wr_stop) state_reg <= (|mask_reg) ? S_PRD : S_IDLE;
          else if (rd_req) state_reg <= S_RWAIT;
        end
        S_PRD: state_reg <= grp_dirty ? S_PWAIT : S_PNEXT;
        S_PWAIT: state_reg <= S_PMRG;
        S_PMRG: state_reg <= S_PNEXT;
        S_PNEXT: state_reg <= (grp_reg == EEG_LAST_GRP) ? S_TWR : S_PRD;
        S_TWR: if (twr_cnt_reg == TWR_LAST) state_reg <= S_IDLE;
        S_RWAIT: state_reg <= S_RCAP;
        S_RCAP: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // =====================================================================
  // page load: only the low seven address bits advance
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_reg <= '0;
      page_reg <= '0;
      arr_id_sel <= 1'b0;
    end else if (state_reg == S_IDLE && wr_begin) begin
      ptr_reg <= wr_addr[EEG_PTR_W-1:0];
      page_reg <= wr_addr[EEG_ADDR_W-1:EEG_PTR_W];
      arr_id_sel <= wr_id_page;
    end else begin
      // reads always target the main array, so an id-page write must not leak into them
      if (rd_take) arr_id_sel <= 1'b0;
      if (state_reg == S_LOAD && wr_data_valid) ptr_reg <= ptr_reg + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (state_reg == S_LOAD && wr_data_valid) buf_mem[ptr_reg] <= wr_data;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_reg <= '0;
    end else if ((state_reg == S_IDLE && wr_begin) || state_reg == S_TWR) begin
      mask_reg <= '0;
    end else if (state_reg == S_LOAD && wr_data_valid) begin
      mask_reg[ptr_reg] <= 1'b1;
    end
  end

  // =====================================================================
  // group walk over the page
  always_ff @(posedge clk) begin
    if (srst) begin
      grp_reg <= '0;
    end else if (state_reg == S_LOAD) begin
      grp_reg <= '0;
    end else if (state_reg == S_PNEXT) begin
      grp_reg <= grp_reg + 5'h01;
    end
  end

  // =====================================================================
  // array port: one group is the unit of every access
  always_ff @(posedge clk) begin
    if (srst) begin
      arr_grp <= '0;
      arr_rd_en <= 1'b0;
      lane_reg <= 2'h0;
    end else begin
      arr_rd_en <= 1'b0;
      if (rd_take) begin
        arr_grp <= rd_addr[EEG_ADDR_W-1:2];
        lane_reg <= rd_addr[1:0];
        arr_rd_en <= 1'b1;
      end else if (state_reg == S_PRD && grp_dirty) begin
        arr_grp <= {page_reg, grp_reg};
        arr_rd_en <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      arr_wr_en <= 1'b0;
      arr_wr_data <= '0;
      arr_wr_chk <= '0;
    end else begin
      arr_wr_en <= (state_reg == S_PMRG);
      if (state_reg == S_PMRG) begin
        arr_wr_data <= merge_word;
        arr_wr_chk <= eeg_check(merge_word);
      end
    end
  end

  // =====================================================================
  // read answer: fixed latency whether or not a bit was repaired
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= (state_reg == S_RCAP);
      if (state_reg == S_RCAP) rd_data <= old_word[8*lane_reg +: 8];
    end
  end

  // =====================================================================
  // write cycle time; the engine holds the bus off while busy
  always_ff @(posedge clk) begin
    if (srst) begin
      twr_cnt_reg <= '0;
      busy <= 1'b0;
    end else begin
      if (state_reg == S_TWR) twr_cnt_reg <= twr_cnt_reg + 17'h00001;
      else twr_cnt_reg <= '0;
      if (state_reg == S_LOAD && wr_stop && |mask_reg) busy <= 1'b1;
      else if (state_reg == S_TWR && twr_cnt_reg == TWR_LAST) busy <= 1'b0;
    end
  end

  // =====================================================================
  // checks
  property p_grp_align;
    @(posedge clk) disable iff (srst)
      arr_wr_en |-> arr_grp == {page_reg, $past(grp_reg, 2)};
  endproperty
  a_grp_align: assert property (p_grp_align) else $error("group address misaligned");

  property p_rd_fix;
    @(posedge clk) disable iff (srst)
      state_reg == S_RCAP && (eeg_check(arr_rd_data) ^ arr_rd_chk) != 6'h00
      |-> eeg_check(old_word) == arr_rd_chk || $countones(old_word ^ arr_rd_data) == 0;
  endproperty
  a_rd_fix: assert property (p_rd_fix) else $error("single bit not repaired");

  property p_rd_lat;
    @(posedge clk) disable iff (srst)
      state_reg == S_IDLE && rd_req && !wr_begin
      |=> !rd_valid ##1 !rd_valid ##1 rd_valid ##1 !rd_valid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency changed");

  property p_wr_chk;
    @(posedge clk) disable iff (srst)
      arr_wr_en |-> arr_wr_chk == eeg_check(arr_wr_data) && $past(arr_rd_en, 2);
  endproperty
  a_wr_chk: assert property (p_wr_chk) else $error("group write without read or checks");

  property p_wr_cycle;
    @(posedge clk) disable iff (srst)
      state_reg == S_LOAD && wr_stop && |mask_reg |=> busy && state_reg == S_PRD;
  endproperty
  a_wr_cycle: assert property (p_wr_cycle) else $error("write cycle not started");

  property p_busy_cause;
    @(posedge clk) disable iff (srst)
      $rose(busy) |-> $past(wr_stop) && $past(state_reg) == S_LOAD;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without stop");

  property p_busy_quiet;
    @(posedge clk) disable iff (srst)
      busy && rd_req |=> !arr_rd_en || state_reg == S_PWAIT;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("request served while busy");

  property p_ptr_wrap;
    @(posedge clk) disable iff (srst)
      state_reg == S_LOAD && wr_data_valid |=> ptr_reg == $past(ptr_reg) + 7'h01
                                              && page_reg == $past(page_reg);
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("page pointer step wrong");

endmodule // eeg_group_ecc

/* eeg_array_model.sv */
// array model: stores each group with its check bits and answers one cycle after a read
`timescale 1ns/1ps
module eeg_array_model
  import eeg_pkg::*;
(
  input wire logic clk,
  input wire logic arr_id_sel,
  input wire logic [EEG_GRP_ADDR_W-1:0] arr_grp,
  input wire logic arr_rd_en,
  input wire logic arr_wr_en,
  input wire logic [EEG_WORD_W-1:0] arr_wr_data,
  input wire logic [EEG_CHK_W-1:0] arr_wr_chk,
  output logic [EEG_WORD_W-1:0] arr_rd_data,
  output logic [EEG_CHK_W-1:0] arr_rd_chk
);
  logic [37:0] mem [logic [14:0]];
  logic [14:0] key;
  assign key = {arr_id_sel, arr_grp};
  initial {arr_rd_chk, arr_rd_data} = '0;
  // =====================================================================
  // outside the answer cycle the lines flip, so a stale word is never mistaken for data
  always @(posedge clk) begin
    if (arr_wr_en) mem[key] = {arr_wr_chk, arr_wr_data};
    if (arr_rd_en) begin
      {arr_rd_chk, arr_rd_data} <= mem.exists(key) ? mem[key] : '0;
    end else begin
      {arr_rd_chk, arr_rd_data} <= ~{arr_rd_chk, arr_rd_data};
    end
  end
endmodule // eeg_array_model

/* eeg_group_ecc_tb.sv */
// self-checking testbench for the group error-correction block
`timescale 1ns/1ps
module eeg_group_ecc_tb;
  import eeg_pkg::*;
  localparam int TW = 20;
  localparam int ENDURANCE = 4000000;
  logic clk = 0, srst = 1, wr_begin = 0, wr_id_page = 0, wr_data_valid = 0, wr_stop = 0;
  logic rd_req = 0, rd_valid, busy, arr_id_sel, arr_rd_en, arr_wr_en;
  logic [15:0] wr_addr = '0, rd_addr = '0;
  logic [7:0] wr_data = '0, rd_data, rf [logic [15:0]];
  logic [13:0] arr_grp;
  logic [31:0] arr_rd_data, arr_wr_data;
  logic [5:0] arr_rd_chk, arr_wr_chk;
  int mismatches = 0, checks = 0, wcnt = 0, idc = 0, wr_total = 0;
  always #20 clk = ~clk;
  eeg_group_ecc #(.TWR_CYCLES(TW)) eeg_group_ecc_i (.clk, .srst, .wr_begin, .wr_id_page,
    .wr_addr, .wr_data_valid, .wr_data, .wr_stop, .rd_req, .rd_addr, .rd_data, .rd_valid,
    .busy, .arr_id_sel, .arr_grp, .arr_rd_en, .arr_rd_data, .arr_rd_chk, .arr_wr_en,
    .arr_wr_data, .arr_wr_chk);
  eeg_array_model eeg_array_model_i (.clk, .arr_id_sel, .arr_grp, .arr_rd_en, .arr_wr_en,
    .arr_wr_data, .arr_wr_chk, .arr_rd_data, .arr_rd_chk);
  // =====================================================================
  // helpers
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] grp_word(input logic [13:0] g);
    logic [31:0] w;
    for (int i = 0; i < 4; i++) w[8*i+:8] = rf.exists({g, 2'(i)}) ? rf[{g, 2'(i)}] : 8'h00;
    return w;
  endfunction
  // every programmed main-array word must be the merge of old and new bytes of its group
  always @(posedge clk) if (arr_wr_en) begin
    wcnt++;
    chk("region", arr_id_sel, idc);
    if (!idc) chk("group word", arr_wr_data, grp_word(arr_grp));
  end
  // =====================================================================
  // bus-side transfers
  task automatic wr(input logic [15:0] a, input int n, input logic id);
    logic [15:0] p;
    logic [31:0] m;
    int t, e;
    m = '0;
    // the host keeps the total count of write transfers over all groups at most ENDURANCE
    if (wr_total >= ENDURANCE) return;
    wr_total++;
    @(negedge clk);
    wr_begin = 1;
    wr_addr = a;
    wr_id_page = id;
    @(negedge clk);
    wr_begin = 0;
    for (int i = 0; i < n; i++) begin
      p = {a[15:7], 7'(a[6:0] + i)};
      m[p[6:2]] = 1'b1;
      wr_data_valid = 1;
      wr_data = 8'($urandom);
      if (!id) rf[p] = wr_data;
      @(negedge clk);
    end
    wr_data_valid = 0;
    wr_stop = 1;
    idc = id;
    wcnt = 0;
    @(negedge clk);
    wr_stop = 0;
    chk("busy after stop", busy, n > 0);
    rd_req = 1;
    rd_addr = a;
    @(negedge clk);
    rd_req = 0;
    repeat (2) @(negedge clk);
    chk("read during write", rd_valid, n == 0);
    for (t = 0; busy && t < 400; t++) @(negedge clk);
    if (busy) begin
      mismatches++;
      test_done();
    end
    // two cycles per clean group, four per dirty one, then the write time
    e = (n == 0) ? 3 : 2 * (EEG_PAGE_BYTES / EEG_GRP_BYTES) + 2 * $countones(m) + TW;
    chk("write time", t + 3, e);
    chk("groups programmed", wcnt, $countones(m));
  endtask
  task automatic rd(input logic [15:0] a, input bit cmp);
    logic [31:0] e;
    e = grp_word(a[15:2]) >> (8 * a[1:0]);
    @(negedge clk);
    rd_req = 1;
    rd_addr = a;
    @(negedge clk);
    rd_req = 0;
    repeat (2) @(negedge clk);
    chk("read answer", rd_valid, 1);
    if (cmp) chk("read data", rd_data, e[7:0]);
  endtask
  // =====================================================================
  // main sequence
  initial begin
    logic [15:0] a;
    logic [37:0] f;
    void'($urandom(32'hA444BF88));
    repeat (4) @(negedge clk);
    srst = 0;
    chk("busy idle", busy, 0);
    a = 16'($urandom);
    wr(a, 1, 0);
    for (int i = 0; i < 4; i++) rd({a[15:2], 2'(i)}, 1);
    wr(a, 0, 0);
    wr({a[15:7], 7'h7E}, 130, 0);
    // random read: address set-up with no data, then the read taken while loading
    @(negedge clk);
    wr_begin = 1;
    wr_addr = a;
    @(negedge clk);
    wr_begin = 0;
    rd({a[15:2], 2'h3}, 1);
    for (int i = 0; i < 24; i++) begin
      a[6:0] = 7'($urandom);
      f = 38'(1) << $urandom_range(37, 0);
      if (i % 4 == 3) f = f | (38'(1) << $urandom_range(37, 0));
      eeg_array_model_i.mem[{1'b0, a[15:2]}] ^= f;
      rd(a, i % 4 != 3);
      eeg_array_model_i.mem[{1'b0, a[15:2]}] ^= f;
    end
    wr(16'($urandom), 5, 1);
    rd(a, 1);
    test_done();
  end
endmodule // eeg_group_ecc_tb
